// *** tpc_consts.vh ***
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH
// ==========================================
// register indices (byte address = 4 * index)
`define TPC_IDX_TEST_CFG 10'h0C7
`define TPC_IDX_ACC_STATE 10'h0C8
`define TPC_IDX_ACC_CMD 10'h0C9
`define TPC_IDX_ACC_BYTE 10'h0CA
`define TPC_IDX_COND_CFG 10'h0CB
`define TPC_IDX_CTRL_EN 10'h0CC
// ==========================================
// reset values
`define TPC_RST_TEST_CFG 4'h0
`define TPC_RST_ACC_CMD 8'h00
`define TPC_RST_ACC_BYTE 8'h00
`define TPC_RST_COND_CFG 8'h80
`define TPC_RST_CTRL_EN 1'b0
// ==========================================
// field positions
`define TPC_TC_LAUNCH 0
`define TPC_TC_DIR 1
`define TPC_TC_MODE_LO 2
`define TPC_CMD_READ_SEL 7
`define TPC_CC_SNAP 7
`define TPC_CC_GSTRK 6
`define TPC_CC_ZCS_LO 3
`define TPC_CC_GSUB_LO 0
`define TPC_CT_TEST 6
`define TPC_CT_STRK 4
`define TPC_CS_SUB_LO 5
// ==========================================
// indirect table base addresses
`define TPC_BASE_SUB 7'h01
`define TPC_BASE_TRK 7'h21
`define TPC_BASE_CFG 7'h41
// ==========================================
// mode encodings
`define TPC_PM_UNFRAMED 2'b00
`define TPC_PM_BYTE 2'b01
`define TPC_PM_SEVEN 2'b10
`define TPC_ZCS_NONE 3'b000
`define TPC_ZCS_B8_SIG7 3'b001
`define TPC_ZCS_JAM8 3'b010
`define TPC_ZCS_B7 3'b011
`define TPC_ZCS_DDS 3'b100
`define TPC_DDS_BYTE 8'h98
`define TPC_SUB_NONE 3'b000
`define TPC_SUB_TRUNK 3'b001
`define TPC_SUB_ALAW 3'b010
`define TPC_SUB_ULAW 3'b011
`define TPC_SUB_LOOP 3'b100
`endif

// *** tpc_top.v ***
`timescale 1ns/100ps
// Behaviour
// RL1 - mode 00: pattern logic takes all 24 channels, test bit ignored
// RL2 - mode 01: pattern takes whole bytes of test-selected channels only
// RL3 - mode 10: pattern takes seven MSBs of test channels; 11 reserved
// RL4 - direction 0: generate in transmit; 1: generate in receive
// RL5 - only a 0 to 1 edge on launch starts the pattern logic
// RL6 - busy reads 1 during indirect access; host waits for 0
// RL7 - command: bit 7 read select, bits 6:0 address; write launches
// RL8 - host targets only 01-18, 21-38, 41-58 indirect addresses
// RL9 - indirect write: load data byte first, then command read select 0
// RL10 - indirect read: command read select 1, then byte holds result
// RL11 - snapshot on: first-frame signaling held for whole superframe
// RL12 - global trunk off: per-channel select; on: all channels use code
// RL13 - bit 1 is MSB; suppression 000 no change; above 100 reserved
// RL14 - code 001 sets bit 8 of zero channel, bit 7 in signaling frames
// RL15 - code 010 sets bit 8 always; 011 sets bit 7 of zero channel
// RL16 - code 100 replaces an all-zero channel with 10011000
// RL17 - replace 000 uses per-channel field; 001 uses channel trunk byte
// RL18 - replace 010 A-law milliwatt; 011 mu-law milliwatt
// RL19 - replace 100 uses receive loopback data; others reserved
// RL20 - master enable clear disables every payload control function
// RL21 - busy rises after command write, falls at end; command writes while busy lost
// RL22 - reserved suppression or replace codes leave data unchanged
`include "tpc_consts.vh"
module tpc_top #(
    parameter NUM_CH = 24
) (
    // clock, enable and reset
    input wire pclk,
    input wire pce,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    // transmit channel stream in
    input wire ch_valid,
    input wire [4:0] ch_index,
    input wire [7:0] ch_data,
    input wire [3:0] tx_signaling_pin,
    input wire sig_frame,
    input wire superframe_mode,
    input wire sf_first_frame,
    input wire [7:0] loopback_data,
    input wire [7:0] pattern_data,
    // transmit channel stream out
    output reg out_valid_q,
    output reg [4:0] out_index_q,
    output reg [7:0] out_data_q,
    output reg [3:0] out_sig_q,
    // pattern generator/detector control
    output reg pattern_take_q,
    output reg [7:0] pattern_mask_q,
    output reg pattern_gen_tx_q,
    output reg pattern_start_q
);

    // ==========================================
    // register state
    reg [3:0] test_cfg_q;
    reg [7:0] acc_cmd_q;
    reg [7:0] acc_byte_q;
    reg [7:0] cond_cfg_q;
    reg master_en_q;
    reg busy_q;
    reg launch_prev_q;
    reg [2:0] mw_phase_q;
    reg [7:0] sub_tbl [0:NUM_CH-1];
    reg [7:0] trk_tbl [0:NUM_CH-1];
    reg [7:0] cfg_tbl [0:NUM_CH-1];
    reg [3:0] snap_tbl [0:NUM_CH-1];

    // ==========================================
    // apb decode
    wire [9:0] idx = paddr[11:2];
    wire hit_tc = (idx == `TPC_IDX_TEST_CFG);
    wire hit_st = (idx == `TPC_IDX_ACC_STATE);
    wire hit_cmd = (idx == `TPC_IDX_ACC_CMD);
    wire hit_byte = (idx == `TPC_IDX_ACC_BYTE);
    wire hit_cc = (idx == `TPC_IDX_COND_CFG);
    wire hit_en = (idx == `TPC_IDX_CTRL_EN);
    wire mapped = hit_tc | hit_st | hit_cmd | hit_byte | hit_cc | hit_en;
    wire acc = psel & penable & pce;
    wire wr = acc & pwrite & mapped;

    // zero wait states; unmapped addresses answer with an error
    assign pready = pce;
    assign pslverr = psel & penable & ~mapped;

    reg [7:0] rd_mux;
    // read data mux, upper bits zero
    always @* begin
        rd_mux = 8'h00;
        if (hit_tc)
            rd_mux = {4'h0, test_cfg_q};
        else if (hit_st)
            rd_mux = {7'h00, busy_q}; // see RL6
        else if (hit_cmd)
            rd_mux = acc_cmd_q;
        else if (hit_byte)
            rd_mux = acc_byte_q;
        else if (hit_cc)
            rd_mux = cond_cfg_q;
        else if (hit_en)
            rd_mux = {7'h00, master_en_q};
    end
    assign prdata = {24'h000000, rd_mux};

    // ==========================================
    // indirect address decode
    wire [6:0] ind_addr = acc_cmd_q[6:0];
    wire in_sub = (ind_addr >= `TPC_BASE_SUB) &&
        (ind_addr < `TPC_BASE_SUB + 7'd24);
    wire in_trk = (ind_addr >= `TPC_BASE_TRK) &&
        (ind_addr < `TPC_BASE_TRK + 7'd24);
    wire in_cfg = (ind_addr >= `TPC_BASE_CFG) &&
        (ind_addr < `TPC_BASE_CFG + 7'd24);
    wire [4:0] ind_ch = ind_addr[4:0] - 5'd1;
    wire ind_rd = acc_cmd_q[`TPC_CMD_READ_SEL];

    reg [7:0] ind_rdata;
    // indirect read mux; addresses outside the tables read zero
    always @* begin
        ind_rdata = 8'h00;
        if (in_sub)
            ind_rdata = sub_tbl[ind_ch];
        else if (in_trk)
            ind_rdata = trk_tbl[ind_ch];
        else if (in_cfg)
            ind_rdata = cfg_tbl[ind_ch];
    end

    // ==========================================
    // direct registers and indirect access sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_cfg_q <= `TPC_RST_TEST_CFG;
            acc_cmd_q <= `TPC_RST_ACC_CMD;
            acc_byte_q <= `TPC_RST_ACC_BYTE;
            cond_cfg_q <= `TPC_RST_COND_CFG;
            master_en_q <= `TPC_RST_CTRL_EN;
            busy_q <= 1'b0;
            launch_prev_q <= 1'b0;
            pattern_start_q <= 1'b0;
        end else if (pce) begin
            if (wr && hit_tc)
                test_cfg_q <= pwdata[3:0];
            if (wr && hit_cc)
                cond_cfg_q <= pwdata[7:0];
            if (wr && hit_en)
                master_en_q <= pwdata[0];
            // command write launches only when idle
            if (wr && hit_cmd && !busy_q) begin
                acc_cmd_q <= pwdata[7:0]; // see RL7
                busy_q <= 1'b1; // see RL21
            end else if (busy_q) begin
                busy_q <= 1'b0; // see RL21
            end
            // completed read loads the byte register
            if (busy_q && ind_rd)
                acc_byte_q <= ind_rdata; // see RL10
            else if (wr && hit_byte)
                acc_byte_q <= pwdata[7:0];
            // launch edge detect
            launch_prev_q <= test_cfg_q[`TPC_TC_LAUNCH];
            pattern_start_q <= test_cfg_q[`TPC_TC_LAUNCH] &
                ~launch_prev_q; // see RL5
        end
    end

    // indirect table write, performed while busy
    always @(posedge pclk) begin
        if (pce && busy_q && !ind_rd) begin
            if (in_sub)
                sub_tbl[ind_ch] <= acc_byte_q; // see RL9
            if (in_trk)
                trk_tbl[ind_ch] <= acc_byte_q;
            if (in_cfg)
                cfg_tbl[ind_ch] <= acc_byte_q;
        end
    end

    // ==========================================
    // per-channel lookups
    wire [1:0] pmode = test_cfg_q[`TPC_TC_MODE_LO +: 2];
    wire [7:0] c_sub = sub_tbl[ch_index];
    wire [7:0] c_trk = trk_tbl[ch_index];
    wire [7:0] c_cfg = cfg_tbl[ch_index];
    wire [2:0] zero_suppress_type = cond_cfg_q[`TPC_CC_ZCS_LO +: 3];
    wire [2:0] gsub = cond_cfg_q[`TPC_CC_GSUB_LO +: 3];
    wire snap_on = cond_cfg_q[`TPC_CC_SNAP] & superframe_mode;

    // milliwatt lookup, one sample per frame
    function [7:0] mw_byte;
        input ulaw;
        input [2:0] ph;
        reg [7:0] b;
        begin
            case (ph[1:0])
                2'd0: b = ulaw ? 8'h1E : 8'h34;
                2'd1: b = ulaw ? 8'h0B : 8'h21;
                2'd2: b = ulaw ? 8'h0B : 8'h21;
                default: b = ulaw ? 8'h1E : 8'h34;
            endcase
            mw_byte = {b[7] | ph[2], b[6:0]};
        end
    endfunction

    // substitution: global code, else the channel's own code
    reg [2:0] sub_sel;
    reg [7:0] sub_data;
    always @* begin
        sub_sel = (gsub == `TPC_SUB_NONE) ?
            c_sub[`TPC_CS_SUB_LO +: 3] : gsub; // see RL17
        case (sub_sel)
            `TPC_SUB_TRUNK: sub_data = c_trk; // see RL17
            `TPC_SUB_ALAW: sub_data = mw_byte(1'b0, mw_phase_q); // see RL18
            `TPC_SUB_ULAW: sub_data = mw_byte(1'b1, mw_phase_q); // see RL18
            `TPC_SUB_LOOP: sub_data = loopback_data; // see RL19
            default: sub_data = ch_data; // see RL22
        endcase
    end

    // zero code suppression; bit 8 is lsb, bit 7 next
    reg [7:0] zcs_data;
    wire all_zero = (sub_data == 8'h00);
    always @* begin
        zcs_data = sub_data; // see RL13
        case (zero_suppress_type)
            `TPC_ZCS_B8_SIG7: begin
                if (all_zero && sig_frame)
                    zcs_data = 8'h02; // see RL14
                else if (all_zero)
                    zcs_data = 8'h01; // see RL14
            end
            `TPC_ZCS_JAM8: zcs_data = {sub_data[7:1], 1'b1}; // see RL15
            `TPC_ZCS_B7: begin
                if (all_zero)
                    zcs_data = 8'h02; // see RL15
            end
            `TPC_ZCS_DDS: begin
                if (all_zero)
                    zcs_data = `TPC_DDS_BYTE; // see RL16
            end
            default: zcs_data = sub_data; // see RL22
        endcase
    end

    // signaling: snapshot source, then trunk conditioning
    wire snap_hold = snap_on & ~sf_first_frame;
    wire [3:0] sig_src = snap_hold ? snap_tbl[ch_index] :
        tx_signaling_pin; // see RL11
    wire strk = cond_cfg_q[`TPC_CC_GSTRK] |
        c_cfg[`TPC_CT_STRK]; // see RL12
    wire [3:0] sig_cond = strk ? c_cfg[3:0] : sig_src; // see RL12

    // pattern takeover selection
    reg take;
    reg [7:0] pmask;
    always @* begin
        take = 1'b0;
        pmask = 8'hFF;
        case (pmode)
            `TPC_PM_UNFRAMED: take = 1'b1; // see RL1
            `TPC_PM_BYTE: take = c_cfg[`TPC_CT_TEST]; // see RL2
            `TPC_PM_SEVEN: begin
                take = c_cfg[`TPC_CT_TEST]; // see RL3
                pmask = 8'hFE;
            end
            default: take = 1'b0;
        endcase
    end

    // generator inserts data only when generating in transmit
    wire gen_tx = ~test_cfg_q[`TPC_TC_DIR]; // see RL4
    wire [7:0] fin_data = (take && gen_tx) ?
        ((pattern_data & pmask) | (zcs_data & ~pmask)) : zcs_data;

    // ==========================================
    // output stage and frame state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q <= 1'b0;
            out_index_q <= 5'd0;
            out_data_q <= 8'h00;
            out_sig_q <= 4'h0;
            pattern_take_q <= 1'b0;
            pattern_mask_q <= 8'h00;
            pattern_gen_tx_q <= 1'b1;
            mw_phase_q <= 3'd0;
        end else if (pce) begin
            out_valid_q <= ch_valid;
            pattern_gen_tx_q <= gen_tx; // see RL4
            if (ch_valid) begin
                out_index_q <= ch_index;
                if (master_en_q) begin
                    out_data_q <= fin_data;
                    out_sig_q <= sig_cond;
                    pattern_take_q <= take;
                    pattern_mask_q <= pmask;
                end else begin
                    out_data_q <= ch_data; // see RL20
                    out_sig_q <= tx_signaling_pin; // see RL20
                    pattern_take_q <= 1'b0; // see RL20
                    pattern_mask_q <= 8'h00;
                end
                if (ch_index == NUM_CH - 1)
                    mw_phase_q <= mw_phase_q + 3'd1;
            end
        end
    end

    // snapshot store, loaded in the superframe's first frame
    always @(posedge pclk) begin
        if (pce && ch_valid && sf_first_frame)
            snap_tbl[ch_index] <= tx_signaling_pin; // see RL11
    end

endmodule // tpc_top

// *** tpc_far_end.sv ***
`timescale 1ns/100ps
// ==========================================
// far side of the stream: receive store and generator bytes
module tpc_far_end (
    // channel on offer
    input wire [4:0] ch_index,
    // receive elastic store byte and generator byte
    output wire [7:0] loopback_data,
    output wire [7:0] pattern_data
);
    // bytes differ per channel so a wrong channel shows up
    assign loopback_data = {3'b101, ch_index};
    assign pattern_data = 8'hC3 ^ {3'b000, ch_index};
endmodule // tpc_far_end

// *** tpc_top_monitor.sv ***
`timescale 1ns/100ps
// ==========================================
// port checker
module tpc_mon #(
    parameter NUM_CH = 24
) (
    // clock and reset
    input wire pclk,
    input wire pce,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // stream
    input wire ch_valid,
    input wire [4:0] ch_index,
    input wire [7:0] ch_data,
    input wire [3:0] tx_signaling_pin,
    input wire out_valid_q,
    input wire [4:0] out_index_q,
    input wire [7:0] out_data_q,
    input wire [3:0] out_sig_q,
    input wire [7:0] pattern_mask_q,
    input wire pattern_start_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic en_q;
    logic mapped;
    // decode of the six mapped words
    assign mapped = paddr inside {12'h31C, 12'h320, 12'h324,
        12'h328, 12'h32C, 12'h330};
    // mirror of the master enable bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_q <= 1'b0;
        else if (psel && penable && pwrite && pce && paddr == 12'h330)
            en_q <= pwdata[0];
    end
    sequence s_take;
        ch_valid && pce;
    endsequence
    sequence s_acc;
        psel && penable;
    endsequence
    chk_out_follow: assert property (s_take |=> out_valid_q &&
        out_index_q == $past(ch_index))
        else $error("output does not follow accepted channel");
    chk_idle_hold: assert property (!ch_valid |=> !out_valid_q &&
        $stable(out_data_q) && $stable(out_sig_q))
        else $error("stream output moved without a channel");
    chk_bypass_data: assert property (s_take and !en_q
        |=> out_data_q == $past(ch_data) &&
        out_sig_q == $past(tx_signaling_pin))
        else $error("disabled block altered channel");
    chk_mask_code: assert property (s_take and en_q |=>
        pattern_mask_q == 8'hFF || pattern_mask_q == 8'hFE)
        else $error("pattern mask not full or seven bit");
    chk_start_pulse: assert property (pattern_start_q
        |=> !pattern_start_q)
        else $error("pattern start longer than one cycle");
    chk_ready_zero: assert property (pready == pce)
        else $error("apb answer not immediate");
    chk_mapped_ok: assert property (s_acc and mapped |-> !pslverr)
        else $error("error on mapped register");
    chk_unmapped_err: assert property (s_acc and !mapped |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_index_range: assert property (out_valid_q |->
        out_index_q < NUM_CH)
        else $error("channel index out of range");
endmodule // tpc_mon
bind tpc_top tpc_mon #(.NUM_CH(NUM_CH)) u_mon (
    .pclk(pclk), .pce(pce), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ch_valid(ch_valid), .ch_index(ch_index),
    .ch_data(ch_data), .tx_signaling_pin(tx_signaling_pin),
    .out_valid_q(out_valid_q), .out_index_q(out_index_q),
    .out_data_q(out_data_q), .out_sig_q(out_sig_q),
    .pattern_mask_q(pattern_mask_q), .pattern_start_q(pattern_start_q)
);

// *** test_tpc_top.sv ***
`timescale 1ns/100ps
`include "tpc_consts.vh"
// ==========================================
// bench for the transmit payload control
module test_tpc_top;
    logic pclk, presetn, psel, penable, pwrite, ch_valid, sig_frame;
    logic sf_mode, sf_first, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [4:0] ch_index;
    logic [7:0] ch_data, q;
    logic [3:0] sig;
    wire pready, pslverr, ov, tk, gtx, st;
    wire [31:0] prdata;
    wire [7:0] lb, pat, m, od;
    wire [4:0] oi;
    wire [3:0] os;
    int err_total, total_checks, starts;
    localparam [11:0] A_TC = {`TPC_IDX_TEST_CFG, 2'b00};
    localparam [11:0] A_ST = {`TPC_IDX_ACC_STATE, 2'b00};
    localparam [11:0] A_CMD = {`TPC_IDX_ACC_CMD, 2'b00};
    localparam [11:0] A_BY = {`TPC_IDX_ACC_BYTE, 2'b00};
    localparam [11:0] A_CC = {`TPC_IDX_COND_CFG, 2'b00};
    localparam [11:0] A_EN = {`TPC_IDX_CTRL_EN, 2'b00};
    localparam logic [7:0] E0 [6] = '{8'h00, 8'h01, 8'h01, 8'h02,
        8'h98, 8'h00};
    localparam logic [7:0] E4 [6] = '{8'h40, 8'h40, 8'h41, 8'h40,
        8'h40, 8'h40};
    tpc_top #(.NUM_CH(24)) DUT (.pclk(pclk), .pce(1'b1),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ch_valid(ch_valid), .ch_index(ch_index), .ch_data(ch_data),
        .tx_signaling_pin(sig), .sig_frame(sig_frame),
        .superframe_mode(sf_mode), .sf_first_frame(sf_first),
        .loopback_data(lb), .pattern_data(pat), .out_valid_q(ov),
        .out_index_q(oi), .out_data_q(od), .out_sig_q(os),
        .pattern_take_q(tk), .pattern_mask_q(m),
        .pattern_gen_tx_q(gtx), .pattern_start_q(st));
    tpc_far_end u_far (.ch_index(ch_index), .loopback_data(lb),
        .pattern_data(pat));
    // ==========================================
    // clock and launch pulse counter
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) if (st) starts <= starts + 1;
    // ==========================================
    // shared tasks
    task chk(input string nm, input [7:0] s, input [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task xf(input w, input [11:0] a, input [7:0] d, output [7:0] r);
        @(posedge pclk);
        {psel, penable, pwrite, paddr} <= {2'b10, w, a};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        r = prdata[7:0];
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rc(input [11:0] a, input [7:0] e);
        xf(0, a, 8'h00, q);
        chk("prdata", q, e);
    endtask
    task idle;
        do xf(0, A_ST, 8'h00, q); while (q[0] !== 1'b0);
    endtask
    task iw(input [6:0] a, input [7:0] d);
        xf(1, A_BY, d, q);
        xf(1, A_CMD, {1'b0, a}, q);
        idle;
    endtask
    task ir(input [6:0] a, input [7:0] e);
        xf(1, A_CMD, {1'b1, a}, q);
        idle;
        rc(A_BY, e);
    endtask
    task sc(input [7:0] d, input [3:0] s, input f, input [7:0] e);
        @(posedge pclk);
        {ch_valid, ch_index, ch_data} <= {1'b1, 5'd3, d};
        {sig, sig_frame} <= {s, f};
        @(posedge pclk);
        ch_valid <= 0;
        #1;
        chk("out_data", od, e);
    endtask
    // ==========================================
    // scenarios
    task t_regs;
        rc(A_TC, 8'h00);
        rc(A_ST, 8'h00);
        rc(A_CMD, 8'h00);
        rc(A_BY, 8'h00);
        rc(A_CC, 8'h80);
        rc(A_EN, 8'h00);
        xf(0, 12'h334, 8'h00, q);
        chk("unmapped", {serr, q[6:0]}, 8'h80);
        xf(1, A_TC, 8'h0C, q);
        xf(1, A_TC, 8'h0D, q);
        xf(1, A_TC, 8'hFF, q);
        rc(A_TC, 8'h0F);
        chk("launches", starts[7:0], 8'h01);
        chk("gen_tx", {7'h0, gtx}, 8'h00);
        xf(1, A_TC, 8'h0C, q);
        // direction output is registered one edge after the register
        repeat (2) @(posedge pclk);
        #1;
        chk("gen_tx", {7'h0, gtx}, 8'h01);
    endtask
    task t_ind;
        iw(7'h04, 8'h00);
        iw(7'h24, 8'hA5);
        iw(7'h44, 8'h09);
        ir(7'h04, 8'h00);
        ir(7'h24, 8'hA5);
        ir(7'h44, 8'h09);
    endtask
    task t_zcs;
        xf(1, A_EN, 8'h01, q);
        for (int z = 0; z < 6; z++) begin
            xf(1, A_CC, 8'(z << 3), q);
            sc(8'h00, 4'h6, 0, E0[z]);
            sc(8'h40, 4'h6, 0, E4[z]);
        end
        xf(1, A_CC, 8'h08, q);
        sc(8'h00, 4'h6, 1, 8'h02);
        xf(1, A_CC, 8'h20, q);
        xf(1, A_EN, 8'h00, q);
        sc(8'h00, 4'h6, 0, 8'h00);
        xf(1, A_EN, 8'h01, q);
    endtask
    task t_sub;
        xf(1, A_CC, 8'h01, q);
        sc(8'h3C, 4'h6, 0, 8'hA5);
        xf(1, A_CC, 8'h04, q);
        sc(8'h3C, 4'h6, 0, 8'hA3);
        xf(1, A_CC, 8'h05, q);
        sc(8'h3C, 4'h6, 0, 8'h3C);
        xf(1, A_CC, 8'h00, q);
        iw(7'h04, 8'h20);
        sc(8'h3C, 4'h6, 0, 8'hA5);
        iw(7'h04, 8'h00);
        sc(8'h3C, 4'h6, 0, 8'h3C);
    endtask
    task t_sig;
        xf(1, A_CC, 8'h40, q);
        sc(8'h11, 4'h6, 0, 8'h11);
        chk("out_sig", {4'h0, os}, 8'h09);
        xf(1, A_CC, 8'h00, q);
        sc(8'h11, 4'h6, 0, 8'h11);
        chk("out_sig", {4'h0, os}, 8'h06);
        iw(7'h44, 8'h19);
        sc(8'h11, 4'h6, 0, 8'h11);
        chk("out_sig", {4'h0, os}, 8'h09);
        iw(7'h44, 8'h09);
        xf(1, A_CC, 8'h80, q);
        {sf_mode, sf_first} <= 2'b11;
        sc(8'h11, 4'h5, 0, 8'h11);
        sf_first <= 0;
        sc(8'h11, 4'hA, 0, 8'h11);
        chk("out_sig", {4'h0, os}, 8'h05);
        sf_mode <= 0;
    endtask
    task t_pat;
        xf(1, A_CC, 8'h00, q);
        xf(1, A_TC, 8'h00, q);
        sc(8'h3C, 4'h6, 0, 8'hC0);
        chk("take", {tk, m[6:0]}, 8'hFF);
        xf(1, A_TC, 8'h04, q);
        sc(8'h3C, 4'h6, 0, 8'h3C);
        chk("take", {7'h0, tk}, 8'h00);
        iw(7'h44, 8'h49);
        sc(8'h3C, 4'h6, 0, 8'hC0);
        xf(1, A_TC, 8'h08, q);
        sc(8'h3D, 4'h6, 0, 8'hC1);
        chk("mask", m, 8'hFE);
        xf(1, A_TC, 8'h0C, q);
        sc(8'h3D, 4'h6, 0, 8'h3D);
        xf(1, A_TC, 8'h06, q);
        sc(8'h3D, 4'h6, 0, 8'h3D);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        {ch_valid, ch_index, ch_data, sig, sig_frame} = 0;
        {sf_mode, sf_first} = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_ind;
        t_zcs;
        t_sub;
        t_sig;
        t_pat;
        conclude;
    end
    initial begin
        #1000000;
        err_total++;
        conclude;
    end
endmodule // test_tpc_top
